//--- inc/pcrp_pkg.sv
package pcrp_pkg;

    // ***************************************
    // Timing
    // ***************************************
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned LOW_SHUTDOWN_US = 85;
    localparam int unsigned LOW_SHUTDOWN_CYC = LOW_SHUTDOWN_US * CLK_MHZ;
    // Longer than the widest legal high phase of 20 us
    localparam int unsigned CMD_IDLE_US = 40;
    localparam int unsigned CMD_IDLE_CYC = CMD_IDLE_US * CLK_MHZ;
    localparam int unsigned CNT_W = 16;

    // ***************************************
    // Pulse counts
    // ***************************************
    localparam logic [5:0] CNT_NEG_FIRST = 6'h01;
    localparam logic [5:0] CNT_NEG_LAST = 6'h29;
    localparam logic [5:0] CNT_POS_FIRST = 6'h2A;
    localparam logic [5:0] CNT_POS_LAST = 6'h2D;
    localparam logic [5:0] CNT_AVDD_FIRST = 6'h2E;
    localparam logic [5:0] CNT_AVDD_LAST = 6'h31;
    localparam logic [5:0] CNT_PANEL_LP = 6'h32;
    localparam logic [5:0] CNT_PANEL_NORM = 6'h33;
    localparam logic [5:0] CNT_AVDD_LP = 6'h34;
    localparam logic [5:0] CNT_AVDD_NORM = 6'h35;
    localparam logic [5:0] CNT_INIT_RESET = 6'h3F;

    // ***************************************
    // Reset values of the rail settings
    // ***************************************
    localparam logic [5:0] NEG_CODE_RST = 6'h0A;
    localparam logic [1:0] POS_CODE_RST = 2'h1;
    localparam logic [1:0] AVDD_CODE_RST = 2'h3;

    // ***************************************
    // Register map and target address
    // ***************************************
    localparam logic [3:0] ADR_CONTROL = 4'h0;
    localparam logic [3:0] ADR_STATUS = 4'h4;
    localparam logic [3:0] ADR_LEVELS = 4'h8;
    localparam logic [3:0] ADR_TARGET = 4'hC;
    localparam int unsigned CTL_DSRC_BIT = 0;
    localparam int unsigned CTL_DREG_BIT = 1;
    localparam logic [6:0] TARGET_ADDR = 7'h3E;

    // Pin vector positions
    localparam int unsigned PIN_CTRL = 0;
    localparam int unsigned PIN_EN = 1;
    localparam int unsigned PIN_DISCHARGE_SELECT_PIN = 2;
    localparam int unsigned PIN_FAULT = 3;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] filt;
        logic [CNT_W-1:0] low_cnt;
        logic [CNT_W-1:0] idle_cnt;
        logic [5:0] pulse_cnt;
        logic pending;
        logic panel_on;
        logic fault;
        logic panel_lp;
        logic avdd_lp;
        logic [5:0] neg_code;
        logic [1:0] pos_code;
        logic [1:0] avdd_code;
        logic dsrc;
        logic dreg;
        logic dis_panel;
        logic dis_avdd;
        logic ack;
        logic [31:0] rdata;
    } pcrp_state_s;

endpackage

//--- core/pcrp_top.sv
`timescale 1ns/10ps

// Notes on behaviour
// - A rising programming pin from off enables both panel rails at the held level codes, 4.6 V and -2.4 V after reset.
// - A programming pin held low switches the panel rails off.
// - The enable pin alone switches the driver-supply rail.
// - Pulses are taken while the enable pin or the programming pin is high, or while the panel rails are on.
// - Rising edges on the programming pin are counted and the count is the command.
// - Counts 1 to 41 load the negative code, -1.4 V down to -5.4 V in 0.1 V steps.
// - Counts 42 to 45 select 4.4, 4.6, 4.8 or 5.0 V on the positive rail.
// - Counts 46 to 49 select 5.5, 6.2, 6.9 or 7.6 V on the driver-supply rail.
// - Counts 50 to 53 set light-load or normal mode on panel and driver rails.
// - Counts 54 to 62 do nothing and count 63 restores all defaults.
// - Start-up defaults are -2.4 V, 4.6 V, 7.6 V and normal mode everywhere.
// - Discharge at shutdown follows the pin unless the source select bit picks the register.
// - The two-wire target address is 0111110 followed by a direction bit.
// - A low phase longer than 85 us is a shutdown request.
// - A latched short-circuit shutdown clears on a low then high programming pin.
module pcrp_top #(
    parameter int unsigned LOW_SHUTDOWN_CYC = pcrp_pkg::LOW_SHUTDOWN_CYC,
    parameter int unsigned CMD_IDLE_CYC = pcrp_pkg::CMD_IDLE_CYC
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic ctrl_pin_i,
    input wire logic en_pin_i,
    input wire logic discharge_select_pin_i,
    input wire logic short_fault_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output logic panel_rail_en_o,
    output logic avdd_rail_en_o,
    output logic [5:0] neg_level_code_o,
    output logic [1:0] pos_level_code_o,
    output logic [1:0] avdd_level_code_o,
    output logic panel_lp_mode_o,
    output logic avdd_lp_mode_o,
    output logic panel_discharge_o,
    output logic avdd_discharge_o
);

    // ***************************************
    // State
    // ***************************************
    pcrp_pkg::pcrp_state_s state_reg;
    pcrp_pkg::pcrp_state_s state_next;

    localparam logic [pcrp_pkg::CNT_W-1:0] LOW_LIM =
        pcrp_pkg::CNT_W'(LOW_SHUTDOWN_CYC);
    localparam logic [pcrp_pkg::CNT_W-1:0] IDLE_LIM =
        pcrp_pkg::CNT_W'(CMD_IDLE_CYC);

    logic [3:0] pins;
    logic [3:0] agree;
    logic ctrl_rise;
    logic ctrl_hi;
    logic en_hi;
    logic flt_hi;
    logic dis_en;
    logic bus_req;
    logic [5:0] cmd;

    assign pins = {short_fault_i, discharge_select_pin_i, en_pin_i,
        ctrl_pin_i};

    // ***************************************
    // Next state
    // ***************************************
    always_comb begin
        state_next = state_reg;

        // Three-stage sync, change taken when stages two and three agree
        state_next.s1 = pins;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        agree = ~(state_reg.s2 ^ state_reg.s3);
        state_next.filt = (state_reg.s2 & agree) |
            (state_reg.filt & ~agree);

        ctrl_hi = state_next.filt[pcrp_pkg::PIN_CTRL];
        en_hi = state_next.filt[pcrp_pkg::PIN_EN];
        flt_hi = state_next.filt[pcrp_pkg::PIN_FAULT];
        ctrl_rise = ctrl_hi & ~state_reg.filt[pcrp_pkg::PIN_CTRL];
        cmd = state_reg.pulse_cnt;

        // Low phase timing
        if (ctrl_hi) begin
            state_next.low_cnt = '0;
        end else if (state_reg.low_cnt < LOW_LIM) begin
            state_next.low_cnt = state_reg.low_cnt + 1'b1;
        end else begin
            // Held low past the limit: shut the panel rails down
            state_next.panel_on = 1'b0;
            state_next.pulse_cnt = '0;
            state_next.pending = 1'b0;
        end

        // Edge counting
        if (ctrl_rise) begin
            if (!state_reg.panel_on || state_reg.fault) begin
                // Enabling edge, also the restart after a latched fault
                state_next.panel_on = 1'b1;
                state_next.fault = 1'b0;
                state_next.pulse_cnt = '0;
                state_next.pending = 1'b0;
            end else begin
                // Saturate so a runaway host cannot wrap to a low code
                if (state_reg.pulse_cnt != pcrp_pkg::CNT_INIT_RESET) begin
                    state_next.pulse_cnt = state_reg.pulse_cnt + 1'b1;
                end
                state_next.pending = 1'b1;
            end
            state_next.idle_cnt = '0;
        end else if (state_reg.pending && ctrl_hi) begin
            if (state_reg.idle_cnt < IDLE_LIM) begin
                state_next.idle_cnt = state_reg.idle_cnt + 1'b1;
            end else begin
                // High long enough: the burst is over, act on the count
                state_next.pending = 1'b0;
                state_next.pulse_cnt = '0;
                if (cmd >= pcrp_pkg::CNT_NEG_FIRST &&
                    cmd <= pcrp_pkg::CNT_NEG_LAST) begin
                    state_next.neg_code =
                        cmd - pcrp_pkg::CNT_NEG_FIRST;
                end else if (cmd >= pcrp_pkg::CNT_POS_FIRST &&
                    cmd <= pcrp_pkg::CNT_POS_LAST) begin
                    state_next.pos_code =
                        2'(cmd - pcrp_pkg::CNT_POS_FIRST);
                end else if (cmd >= pcrp_pkg::CNT_AVDD_FIRST &&
                    cmd <= pcrp_pkg::CNT_AVDD_LAST) begin
                    state_next.avdd_code =
                        2'(cmd - pcrp_pkg::CNT_AVDD_FIRST);
                end else begin
                    case (cmd)
                        pcrp_pkg::CNT_PANEL_LP: begin
                            state_next.panel_lp = 1'b1;
                        end
                        pcrp_pkg::CNT_PANEL_NORM: begin
                            state_next.panel_lp = 1'b0;
                        end
                        pcrp_pkg::CNT_AVDD_LP: begin
                            state_next.avdd_lp = 1'b1;
                        end
                        pcrp_pkg::CNT_AVDD_NORM: begin
                            state_next.avdd_lp = 1'b0;
                        end
                        pcrp_pkg::CNT_INIT_RESET: begin
                            state_next.neg_code =
                                pcrp_pkg::NEG_CODE_RST;
                            state_next.pos_code = pcrp_pkg::POS_CODE_RST;
                            state_next.avdd_code = pcrp_pkg::AVDD_CODE_RST;
                            state_next.panel_lp = 1'b0;
                            state_next.avdd_lp = 1'b0;
                        end
                        default: begin
                            // Counts 54 to 62 and zero change nothing
                            state_next.pending = 1'b0;
                        end
                    endcase
                end
            end
        end else if (!ctrl_hi) begin
            state_next.idle_cnt = '0;
        end

        // Link ignored while both pins are low; low phases of a burst
        // with the panel rails on still belong to the link
        if (!en_hi && !ctrl_hi && !state_next.panel_on) begin
            state_next.pulse_cnt = '0;
            state_next.pending = 1'b0;
        end

        // Fault latch; set wins over a restart edge in the same cycle
        if (flt_hi && state_next.panel_on) begin
            state_next.fault = 1'b1;
        end

        // Discharge source
        dis_en = state_reg.dsrc ? state_reg.dreg
            : state_next.filt[pcrp_pkg::PIN_DISCHARGE_SELECT_PIN];
        state_next.dis_panel = dis_en &
            ~(state_next.panel_on & ~state_next.fault);
        state_next.dis_avdd = dis_en & ~en_hi;

        // ***************************************
        // Wishbone slave
        // ***************************************
        bus_req = wb_cyc_i & wb_stb_i & ~state_reg.ack;
        state_next.ack = bus_req;
        state_next.rdata = '0;
        if (bus_req) begin
            case (wb_adr_i)
                pcrp_pkg::ADR_CONTROL: begin
                    state_next.rdata = {30'h00000000, state_reg.dreg,
                        state_reg.dsrc};
                end
                pcrp_pkg::ADR_STATUS: begin
                    state_next.rdata = {18'h00000, state_reg.pulse_cnt,
                        2'h0, dis_en, state_reg.avdd_lp,
                        state_reg.panel_lp, state_reg.fault,
                        state_reg.filt[pcrp_pkg::PIN_EN],
                        state_reg.panel_on};
                end
                pcrp_pkg::ADR_LEVELS: begin
                    state_next.rdata = {18'h00000, state_reg.avdd_code,
                        2'h0, state_reg.pos_code, 2'h0,
                        state_reg.neg_code};
                end
                pcrp_pkg::ADR_TARGET: begin
                    state_next.rdata = {25'h0000000,
                        pcrp_pkg::TARGET_ADDR};
                end
                default: begin
                    // Unmapped: acknowledged, reads zero, writes dropped
                    state_next.rdata = '0;
                end
            endcase
        end
        // Write lands at the edge where the master sees ack high
        if (wb_cyc_i && wb_stb_i && wb_we_i && state_reg.ack &&
            wb_sel_i[0] && wb_adr_i == pcrp_pkg::ADR_CONTROL) begin
            state_next.dsrc = wb_dat_i[pcrp_pkg::CTL_DSRC_BIT];
            state_next.dreg = wb_dat_i[pcrp_pkg::CTL_DREG_BIT];
        end
    end

    // ***************************************
    // Registers
    // ***************************************
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= '0;
            state_reg.neg_code <= pcrp_pkg::NEG_CODE_RST;
            state_reg.pos_code <= pcrp_pkg::POS_CODE_RST;
            state_reg.avdd_code <= pcrp_pkg::AVDD_CODE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ***************************************
    // Outputs
    // ***************************************
    assign wb_ack_o = state_reg.ack;
    assign wb_dat_o = state_reg.rdata;
    // Fault drops the panel rails but keeps settings for the restart
    assign panel_rail_en_o = state_reg.panel_on & ~state_reg.fault;
    assign avdd_rail_en_o = state_reg.filt[pcrp_pkg::PIN_EN];
    assign neg_level_code_o = state_reg.neg_code;
    assign pos_level_code_o = state_reg.pos_code;
    assign avdd_level_code_o = state_reg.avdd_code;
    assign panel_lp_mode_o = state_reg.panel_lp;
    assign avdd_lp_mode_o = state_reg.avdd_lp;
    assign panel_discharge_o = state_reg.dis_panel;
    assign avdd_discharge_o = state_reg.dis_avdd;

endmodule // pcrp_top

//--- tb/pcrp_host_model.sv
`timescale 1ns/10ps
module pcrp_host_model (
    input wire logic clk_i,
    output logic ctrl_pin_o
);
    initial ctrl_pin_o = 1'b0;

    // Caller enters just after a rising edge; pin then holds n cycles
    task automatic level(logic v, int n);
        ctrl_pin_o <= v;
        repeat (n) @(posedge clk_i);
    endtask

    // ph stays under the idle and shutdown counts of the bench
    task automatic pulses(int n, int ph);
        for (int i = 0; i < n; i++) begin
            level(1'b0, ph);
            level(1'b1, ph);
        end
    endtask

    // Settle time before the first pulse
    task automatic power_on(int wait_cyc);
        level(1'b1, wait_cyc);
    endtask
endmodule // pcrp_host_model

//--- tb/pcrp_sva.sv
`timescale 1ns/10ps
module pcrp_sva #(
    parameter int unsigned LOW_SHUTDOWN_CYC = 60
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic ctrl_pin_i,
    input wire logic en_pin_i,
    input wire logic short_fault_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic panel_rail_en_o,
    input wire logic avdd_rail_en_o,
    input wire logic [5:0] neg_level_code_o,
    input wire logic [1:0] pos_level_code_o,
    input wire logic [1:0] avdd_level_code_o,
    input wire logic panel_lp_mode_o,
    input wire logic avdd_lp_mode_o,
    input wire logic panel_discharge_o
);
    // ***************************************
    // Low phase length, saturating
    // ***************************************
    logic [15:0] low_cnt_reg;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_cnt_reg <= 16'h0;
        end else if (ctrl_pin_i) begin
            low_cnt_reg <= 16'h0;
        end else if (low_cnt_reg != 16'hFFFF) begin
            low_cnt_reg <= low_cnt_reg + 16'h1;
        end
    end

    // ***************************************
    // Properties
    // ***************************************
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_long_low;
        low_cnt_reg > 16'(LOW_SHUTDOWN_CYC + 8);
    endsequence
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (s_req |=> wb_ack_o)
        else $error("ack missing after request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_avdd_follow: assert property (en_pin_i [*8] |-> avdd_rail_en_o)
        else $error("driver rail not on with enable pin");
    a_panel_down: assert property (s_long_low |-> !panel_rail_en_o)
        else $error("panel rails on after long low");
    a_codes_hold: assert property (!$stable({neg_level_code_o,
        pos_level_code_o, avdd_level_code_o, panel_lp_mode_o,
        avdd_lp_mode_o}) |-> $past(ctrl_pin_i, 2))
        else $error("setting changed without held pin");
    a_neg_range: assert property (neg_level_code_o <= 6'h28)
        else $error("negative code out of range");
    a_panel_rise: assert property ($rose(panel_rail_en_o)
        |-> ctrl_pin_i && $past(ctrl_pin_i, 3))
        else $error("panel rails on without pin high");
    a_fault_off: assert property (short_fault_i [*8] |-> !panel_rail_en_o)
        else $error("panel rails on during fault");
    a_dis_off: assert property (panel_discharge_o |-> !panel_rail_en_o)
        else $error("discharge while panel rails on");
endmodule // pcrp_sva

bind pcrp_top pcrp_sva #(.LOW_SHUTDOWN_CYC(LOW_SHUTDOWN_CYC)) u_sva (
    .sys_clk_i, .resetn_i, .ctrl_pin_i, .en_pin_i, .short_fault_i,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .panel_rail_en_o,
    .avdd_rail_en_o, .neg_level_code_o, .pos_level_code_o,
    .avdd_level_code_o, .panel_lp_mode_o, .avdd_lp_mode_o,
    .panel_discharge_o
);

//--- tb/tb.sv
`timescale 1ns/10ps
module tb;
    // Short counts keep the run brief
    localparam int LSD = 60;
    localparam int IDLE = 30;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b0, dsel = 1'b0, flt = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rd, dato;
    logic ctrl, ack, pen, aen, plp, alp, pdis, adis;
    logic [5:0] neg;
    logic [1:0] pos, avd;
    int num_errors = 0;
    int cmp_count = 0;

    always #2 clk = ~clk;

    pcrp_host_model host (.clk_i(clk), .ctrl_pin_o(ctrl));

    pcrp_top #(.LOW_SHUTDOWN_CYC(LSD), .CMD_IDLE_CYC(IDLE)) dut (
        .sys_clk_i(clk), .resetn_i(rst_n), .ctrl_pin_i(ctrl),
        .en_pin_i(en), .discharge_select_pin_i(dsel), .short_fault_i(flt),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(dato),
        .panel_rail_en_o(pen), .avdd_rail_en_o(aen),
        .neg_level_code_o(neg), .pos_level_code_o(pos),
        .avdd_level_code_o(avd), .panel_lp_mode_o(plp),
        .avdd_lp_mode_o(alp), .panel_discharge_o(pdis),
        .avdd_discharge_o(adis)
    );

    // ***************************************
    // Shared tasks
    // ***************************************
    task automatic complete_run();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wb(logic w, logic [3:0] a, logic [31:0] d,
                      output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        chk("ack", 32'h1, 32'(ack));
        r = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    // Expectation packs neg, pos, driver level and both mode bits
    task automatic cmd(int n, int ph, logic [11:0] e);
        host.pulses(n, ph);
        repeat (IDLE + 10) @(posedge clk);
        chk("levels", 32'(e), 32'({neg, pos, avd, plp, alp}));
    endtask

    // ***************************************
    // Scenarios
    // ***************************************
    task automatic t_regs();
        wb(1'b0, pcrp_pkg::ADR_TARGET, 32'h0, rd);
        chk("target", 32'h3E, rd);
        wb(1'b1, 4'h2, 32'hFF, rd);
        wb(1'b0, 4'h2, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        wb(1'b1, pcrp_pkg::ADR_CONTROL, 32'h3, rd);
        wb(1'b0, pcrp_pkg::ADR_CONTROL, 32'h0, rd);
        chk("control", 32'h3, rd);
    endtask

    task automatic t_cmds();
        cmd(39, 8, {6'h26, 2'h1, 2'h3, 2'h0});
        cmd(1, 20, {6'h00, 2'h1, 2'h3, 2'h0});
        cmd(41, 8, {6'h28, 2'h1, 2'h3, 2'h0});
        for (int i = 0; i < 4; i++) begin
            cmd(42 + i, 8, {6'h28, 2'(i), 2'h3, 2'h0});
        end
        for (int i = 0; i < 4; i++) begin
            cmd(46 + i, 8, {6'h28, 2'h3, 2'(i), 2'h0});
        end
        cmd(50, 8, {6'h28, 2'h3, 2'h3, 2'h2});
        cmd(52, 8, {6'h28, 2'h3, 2'h3, 2'h3});
        cmd(55, 8, {6'h28, 2'h3, 2'h3, 2'h3});
        cmd(51, 8, {6'h28, 2'h3, 2'h3, 2'h1});
        cmd(53, 8, {6'h28, 2'h3, 2'h3, 2'h0});
        cmd(50, 8, {6'h28, 2'h3, 2'h3, 2'h2});
        cmd(63, 8, {6'h0A, 2'h1, 2'h3, 2'h0});
    endtask

    task automatic t_enable_fault();
        en <= 1'b1;
        repeat (10) @(posedge clk);
        chk("avdd on", 32'h3, 32'({aen, pen}));
        flt <= 1'b1;
        repeat (10) @(posedge clk);
        chk("fault", 32'h2, 32'({aen, pen}));
        flt <= 1'b0;
        host.level(1'b0, 10);
        host.level(1'b1, 10);
        chk("fault clear", 32'h1, 32'(pen));
        en <= 1'b0;
        repeat (IDLE + 10) @(posedge clk);
        chk("avdd off", 32'h1, 32'({aen, pen}));
    endtask

    task automatic t_shutdown();
        wb(1'b1, pcrp_pkg::ADR_CONTROL, 32'h0, rd);
        dsel <= 1'b1;
        host.level(1'b0, LSD + 20);
        chk("panel off", 32'h0, 32'(pen));
        chk("pin discharge", 32'h1, 32'(pdis));
        wb(1'b1, pcrp_pkg::ADR_CONTROL, 32'h1, rd);
        repeat (4) @(posedge clk);
        chk("reg no discharge", 32'h0, 32'(pdis));
        wb(1'b1, pcrp_pkg::ADR_CONTROL, 32'h3, rd);
        repeat (4) @(posedge clk);
        chk("reg discharge", 32'h1, 32'(pdis));
    endtask

    // ***************************************
    // Main sequence and watchdog
    // ***************************************
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("reset", 32'h538, 32'({neg, pos, avd, plp, alp, pen}));
        t_regs();
        host.power_on(40);
        chk("panel on", 32'h538, 32'({neg, pos, avd, plp, alp, ~pen}));
        t_cmds();
        t_enable_fault();
        t_shutdown();
        complete_run();
    end

    // Whole sequence needs about 14k cycles
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        complete_run();
    end
endmodule // tb
